// >>> design/gtimer_pkg.sv
// constants shared by the dual half timer and its half counter
// assumes a single system clock domain
package gtimer_pkg;
  localparam logic [2:0]  CFG_32_PERIODIC = 3'h0;
  localparam logic [2:0]  CFG_32_CLOCK    = 3'h1;
  localparam logic [2:0]  CFG_SPLIT_16    = 3'h4;
  localparam logic [1:0]  MODE_ONE_SHOT   = 2'h1;
  localparam logic [1:0]  MODE_PERIODIC   = 2'h2;
  localparam logic [15:0] HALF_ONES       = 16'hffff;
  localparam logic [15:0] HALF_ZERO       = 16'h0000;
  localparam logic [7:0]  PRESCALE_RESET  = 8'h00;
  localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;
  localparam logic [31:0] WORD_ONE        = 32'h0000_0001;
  localparam logic [31:0] WORD_INC        = 32'h0000_0001;
  localparam logic [15:0] HALF_DEC        = 16'h0001;
  localparam logic [7:0]  PRE_DEC         = 8'h01;
  // clock input edges per second tick
  localparam int          CLOCK_IN_HZ     = 32768;
  localparam logic [14:0] CLOCK_DIV_LAST  = 15'(CLOCK_IN_HZ - 1);
  localparam logic [14:0] CLOCK_DIV_ZERO  = 15'h0000;
  localparam logic [14:0] CLOCK_DIV_INC   = 15'h0001;
endpackage

// >>> design/half_ctrl_if.sv
// signals passed between the timer top and one 16-bit half
// assumes both ends share clk_sys
`timescale 1ns/1ps
interface half_ctrl_if;
  logic        enable;
  logic        periodic;
  logic        stall;
  logic        load_we;
  logic [15:0] load_val;
  logic [7:0]  prescale;
  logic [15:0] count;
  logic        timeout;
  logic        stop;
  modport top  (output enable, periodic, stall, load_we, load_val, prescale,
                input count, timeout, stop);
  modport half (input enable, periodic, stall, load_we, load_val, prescale,
                output count, timeout, stop);
endinterface

// >>> design/half_counter.sv
// one 16-bit down-counter with 8-bit prescaler, split mode only
// assumes config is steady while enabled
`timescale 1ns/1ps
module half_counter (
  // clock and reset
  input  wire logic   clk_sys,
  input  wire logic   rst_b,
  // control from top
  half_ctrl_if.half   ctl
);
  logic [15:0] cnt_r;
  logic [7:0]  pre_r;
  logic        at_zero;
  logic        step;
  logic        zero_seen_r;

  assign ctl.count = cnt_r;
  assign at_zero   = (cnt_r == gtimer_pkg::HALF_ZERO);
  assign step      = ctl.enable && !ctl.stall && (pre_r == gtimer_pkg::PRESCALE_RESET);
  assign ctl.timeout = step && at_zero && !zero_seen_r;
  assign ctl.stop    = ctl.timeout && !ctl.periodic;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_r       <= gtimer_pkg::HALF_ONES;
      pre_r       <= gtimer_pkg::PRESCALE_RESET;
      zero_seen_r <= 1'b0;
    end
    else if (ctl.load_we)
    begin
      cnt_r       <= ctl.load_val;
      pre_r       <= ctl.prescale;
      zero_seen_r <= 1'b0;
    end
    else if (step)
    begin
      // reload happens on the step after zero so zero is seen for one tick
      if (at_zero && zero_seen_r)
      begin
        cnt_r       <= ctl.load_val;
        pre_r       <= ctl.prescale;
        zero_seen_r <= 1'b0;
      end
      else if (at_zero)
        zero_seen_r <= 1'b1;
      else
      begin
        cnt_r <= cnt_r - gtimer_pkg::HALF_DEC;
        pre_r <= ctl.prescale;
      end
    end
    else if (ctl.enable && !ctl.stall)
      pre_r <= pre_r - gtimer_pkg::PRE_DEC;
  end
endmodule

// >>> design/dual_half_general_timer.sv
// general timer block: two 16-bit halves, 32-bit down counter, 32-bit clock counter
// assumes configuration changes only while disabled; clock pin is asynchronous
`timescale 1ns/1ps
module dual_half_general_timer (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // configuration
  input  wire logic [2:0]  configuration_selector,
  input  wire logic [1:0]  low_half_mode_field,
  input  wire logic [1:0]  half_mode_field_high,
  input  wire logic [7:0]  low_half_prescale_register,
  input  wire logic [7:0]  high_half_prescale_register,
  // control bits
  input  wire logic        low_half_enable_set,
  input  wire logic        low_half_enable_clr,
  input  wire logic        high_half_enable_set,
  input  wire logic        high_half_enable_clr,
  input  wire logic        low_half_stall_bit,
  input  wire logic        high_half_stall_bit,
  input  wire logic        low_trigger_output_enable,
  input  wire logic        high_trigger_output_enable,
  input  wire logic        clock_stall_ignore_enable,
  // load and match writes
  input  wire logic        low_load_we,
  input  wire logic [31:0] low_load_wdata,
  input  wire logic        high_load_we,
  input  wire logic [15:0] high_load_wdata,
  input  wire logic        match_we,
  input  wire logic [31:0] match_wdata,
  // mask and clear
  input  wire logic        low_timeout_mask,
  input  wire logic        high_timeout_mask,
  input  wire logic        clock_match_mask,
  input  wire logic        low_timeout_clear,
  input  wire logic        high_timeout_clear,
  input  wire logic        clock_match_clear_bit,
  // external 32.768 khz pin
  input  wire logic        capture_pin_zero,
  // status
  output logic             low_half_enable_bit,
  output logic             high_half_enable_bit,
  output logic [31:0]      low_half_counter_value,
  output logic [15:0]      high_half_counter_value,
  output logic [31:0]      low_half_interval_load,
  output logic [15:0]      high_half_interval_load,
  output logic             low_timeout_raw_flag,
  output logic             high_timeout_raw_flag,
  output logic             clock_match_raw_flag,
  output logic             low_timeout_masked_flag,
  output logic             high_timeout_masked_flag,
  output logic             clock_match_masked_flag,
  output logic             timer_irq,
  output logic             converter_trigger
);
  half_ctrl_if lo_if ();
  half_ctrl_if hi_if ();

  logic        en_lo_r, en_hi_r;
  logic [15:0] ld_lo_r, ld_hi_r;
  logic [31:0] cnt32_r, match_r;
  logic        zero32_seen_r;
  logic        raw_lo_r, raw_hi_r, raw_rtc_r;
  logic        trig_r, irq_r;
  logic [31:0] cnt_view_r;
  logic        mis_lo_r, mis_hi_r, mis_rtc_r;
  logic [1:0]  pin_sync_r;
  logic        pin_prev_r;
  logic [14:0] div_r;
  logic        rtc_active_r;

  wire mode32   = (configuration_selector == gtimer_pkg::CFG_32_PERIODIC);
  wire mode_rtc = (configuration_selector == gtimer_pkg::CFG_32_CLOCK);
  wire split    = (configuration_selector == gtimer_pkg::CFG_SPLIT_16);
  wire wide     = mode32 || mode_rtc;
  wire periodic32 = (low_half_mode_field == gtimer_pkg::MODE_PERIODIC);
  wire run32    = mode32 && en_lo_r && !low_half_stall_bit;
  wire zero32   = (cnt32_r == gtimer_pkg::WORD_ZERO);
  wire tmo32    = run32 && zero32 && !zero32_seen_r;
  wire stop32   = tmo32 && !periodic32;
  wire rtc_stalled = (low_half_stall_bit || high_half_stall_bit) && !clock_stall_ignore_enable;
  wire pin_rise = pin_sync_r[1] && !pin_prev_r;
  wire sec_tick = pin_rise && (div_r == gtimer_pkg::CLOCK_DIV_LAST);
  wire rtc_step = mode_rtc && en_lo_r && !rtc_stalled && sec_tick;
  wire rtc_hit  = rtc_step && (cnt32_r == match_r);
  wire tmo_lo   = wide ? tmo32 : (split && lo_if.timeout);
  wire tmo_hi   = split && hi_if.timeout;
  wire [31:0] load32 = {ld_hi_r, ld_lo_r};
  wire stop_lo  = wide ? stop32 : (split && lo_if.stop);
  wire stop_hi  = split && hi_if.stop;
  wire raw_lo_nxt  = tmo_lo || (raw_lo_r && !low_timeout_clear);
  wire raw_hi_nxt  = tmo_hi || (raw_hi_r && !high_timeout_clear);
  wire raw_rtc_nxt = rtc_hit || (raw_rtc_r && !clock_match_clear_bit);

  assign lo_if.enable   = split && en_lo_r;
  assign lo_if.periodic = (low_half_mode_field == gtimer_pkg::MODE_PERIODIC);
  assign lo_if.stall    = low_half_stall_bit;
  assign lo_if.load_we  = split && low_load_we;
  assign lo_if.load_val = split && low_load_we ? low_load_wdata[15:0] : ld_lo_r;
  assign lo_if.prescale = low_half_prescale_register;
  assign hi_if.enable   = split && en_hi_r;
  assign hi_if.periodic = (half_mode_field_high == gtimer_pkg::MODE_PERIODIC);
  assign hi_if.stall    = high_half_stall_bit;
  assign hi_if.load_we  = split && high_load_we;
  assign hi_if.load_val = split && high_load_we ? high_load_wdata : ld_hi_r;
  assign hi_if.prescale = high_half_prescale_register;

  half_counter u_lo (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .ctl     (lo_if.half)
  );

  half_counter u_hi (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .ctl     (hi_if.half)
  );

  // pin synchroniser; only the second stage feeds edge detection
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_sync_r <= 2'h0;
      pin_prev_r <= 1'b0;
      div_r      <= gtimer_pkg::CLOCK_DIV_ZERO;
    end
    else
    begin
      pin_sync_r <= {pin_sync_r[0], capture_pin_zero};
      pin_prev_r <= pin_sync_r[1];
      if (!(mode_rtc && en_lo_r))
        div_r <= gtimer_pkg::CLOCK_DIV_ZERO;
      else if (sec_tick)
        div_r <= gtimer_pkg::CLOCK_DIV_ZERO;
      else if (pin_rise)
        div_r <= div_r + gtimer_pkg::CLOCK_DIV_INC;
    end
  end

  // enables: hardware stop of a one-shot wins over a software set in that cycle
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      en_lo_r <= 1'b0;
      en_hi_r <= 1'b0;
    end
    else
    begin
      en_lo_r <= !stop_lo && (low_half_enable_set || (en_lo_r && !low_half_enable_clr));
      en_hi_r <= !stop_hi && (high_half_enable_set || (en_hi_r && !high_half_enable_clr));
    end
  end

  // load registers
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ld_lo_r <= gtimer_pkg::HALF_ONES;
      ld_hi_r <= gtimer_pkg::HALF_ONES;
      match_r <= gtimer_pkg::WORD_ZERO;
    end
    else
    begin
      if (low_load_we && wide)
      begin
        ld_lo_r <= low_load_wdata[15:0];
        ld_hi_r <= low_load_wdata[31:16];
      end
      else
      begin
        if (low_load_we)
          ld_lo_r <= low_load_wdata[15:0];
        if (high_load_we)
          ld_hi_r <= high_load_wdata;
      end
      if (match_we)
        match_r <= match_wdata;
    end
  end

  // 32-bit counter shared by down and clock modes
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt32_r       <= {gtimer_pkg::HALF_ONES, gtimer_pkg::HALF_ONES};
      zero32_seen_r <= 1'b0;
      rtc_active_r  <= 1'b0;
    end
    else
    begin
      rtc_active_r <= mode_rtc;
      if (mode_rtc && !rtc_active_r)
        cnt32_r <= gtimer_pkg::WORD_ONE;
      else if (mode32 && low_load_we)
      begin
        cnt32_r       <= low_load_wdata;
        zero32_seen_r <= 1'b0;
      end
      else if (rtc_hit)
        cnt32_r <= gtimer_pkg::WORD_ZERO;
      else if (rtc_step)
        cnt32_r <= cnt32_r + gtimer_pkg::WORD_INC;
      else if (run32)
      begin
        if (zero32 && zero32_seen_r)
        begin
          cnt32_r       <= load32;
          zero32_seen_r <= 1'b0;
        end
        else if (zero32)
          zero32_seen_r <= 1'b1;
        else
          cnt32_r <= cnt32_r - gtimer_pkg::WORD_INC;
      end
    end
  end

  // sticky status: a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      raw_lo_r  <= 1'b0;
      raw_hi_r  <= 1'b0;
      raw_rtc_r <= 1'b0;
      mis_lo_r  <= 1'b0;
      mis_hi_r  <= 1'b0;
      mis_rtc_r <= 1'b0;
      irq_r     <= 1'b0;
      trig_r    <= 1'b0;
    end
    else
    begin
      raw_lo_r  <= raw_lo_nxt;
      raw_hi_r  <= raw_hi_nxt;
      raw_rtc_r <= raw_rtc_nxt;
      mis_lo_r  <= raw_lo_nxt && low_timeout_mask;
      mis_hi_r  <= raw_hi_nxt && high_timeout_mask;
      mis_rtc_r <= raw_rtc_nxt && clock_match_mask;
      irq_r     <= (raw_lo_nxt && low_timeout_mask) || (raw_hi_nxt && high_timeout_mask)
                   || (raw_rtc_nxt && clock_match_mask);
      trig_r    <= (tmo_lo && low_trigger_output_enable)
                   || (tmo_hi && high_trigger_output_enable);
    end
  end

  // registered view of the count; enables drive their outputs directly
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      cnt_view_r <= {gtimer_pkg::HALF_ONES, gtimer_pkg::HALF_ONES};
    else
      cnt_view_r <= wide ? cnt32_r : {hi_if.count, lo_if.count};
  end

  assign low_half_enable_bit      = en_lo_r;
  assign high_half_enable_bit     = en_hi_r;
  assign low_half_counter_value   = wide ? cnt_view_r : {gtimer_pkg::HALF_ZERO, cnt_view_r[15:0]};
  assign high_half_counter_value  = cnt_view_r[31:16];
  assign low_half_interval_load   = wide ? load32 : {gtimer_pkg::HALF_ZERO, ld_lo_r};
  assign high_half_interval_load  = ld_hi_r;
  assign low_timeout_raw_flag     = raw_lo_r;
  assign high_timeout_raw_flag    = raw_hi_r;
  assign clock_match_raw_flag     = raw_rtc_r;
  assign low_timeout_masked_flag  = mis_lo_r;
  assign high_timeout_masked_flag = mis_hi_r;
  assign clock_match_masked_flag  = mis_rtc_r;
  assign timer_irq                = irq_r;
  assign converter_trigger        = trig_r;
endmodule

// >>> test/capture_clock_source.sv
// far-side source of the 32.768 khz clock pin used in clock mode
// assumes the bench raises run only while clock mode is exercised
`timescale 1ns/1ps
module capture_clock_source (
  // clock and control
  input  wire logic clk_sys,
  input  wire logic run,
  // clock pin
  output logic      pin
);
  // two system clocks per pin period keeps the run short; the counter only
  // sees the edge count, so the division ratio is still exercised in full
  initial pin = 1'h0;
  // pin stands still outside the clock-mode test
  always @(posedge clk_sys)
    pin <= #1 run ? ~pin : 1'h0;
endmodule

// >>> test/dual_half_general_timer_assertions.sv
// port-level checker for the dual half general timer
// assumes one clock domain; bound to the top module below
`timescale 1ns/1ps
module dual_half_general_timer_assertions (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_b,
  // stimulus seen
  input wire logic [2:0]  configuration_selector,
  input wire logic        low_load_we,
  input wire logic [31:0] low_load_wdata,
  input wire logic        low_timeout_clear,
  input wire logic        low_trigger_output_enable,
  input wire logic        high_trigger_output_enable,
  // design outputs
  input wire logic        low_half_enable_bit,
  input wire logic        high_half_enable_bit,
  input wire logic [31:0] low_half_counter_value,
  input wire logic [31:0] low_half_interval_load,
  input wire logic [15:0] high_half_interval_load,
  input wire logic        low_timeout_raw_flag,
  input wire logic        high_timeout_raw_flag,
  input wire logic        low_timeout_masked_flag,
  input wire logic        high_timeout_masked_flag,
  input wire logic        clock_match_masked_flag,
  input wire logic        timer_irq,
  input wire logic        converter_trigger
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_wide_load;
    low_load_we && configuration_selector == gtimer_pkg::CFG_32_PERIODIC;
  endsequence
  // selector held over two samples so the registered view mux cannot move
  sequence s_idle_hold;
    !low_half_enable_bit && !low_load_we && $stable(configuration_selector)
      ##1 $stable(configuration_selector);
  endsequence
  a_reset_state:
    assert property ($rose(rst_b) |-> low_half_interval_load == 32'hffff_ffff
      && !low_half_enable_bit && !high_half_enable_bit && !timer_irq)
    else $error("state after reset wrong");
  a_wide_load:
    assert property (s_wide_load |=> {high_half_interval_load,
      low_half_interval_load[15:0]} == $past(low_load_wdata))
    else $error("wide load split wrong");
  a_load_view:
    assert property (s_wide_load |-> ##2 low_half_counter_value == $past(low_load_wdata, 2))
    else $error("loaded count not shown");
  a_idle_hold:
    assert property (s_idle_hold |=> $stable(low_half_counter_value))
    else $error("disabled counter moved");
  a_trig_pulse:
    assert property (converter_trigger |=> !converter_trigger)
    else $error("trigger longer than one cycle");
  a_trig_cause:
    assert property (converter_trigger |-> ($past(low_trigger_output_enable)
      || $past(high_trigger_output_enable)) && (low_timeout_raw_flag || high_timeout_raw_flag))
    else $error("trigger without cause");
  a_masked_raw:
    assert property (low_timeout_masked_flag |-> low_timeout_raw_flag)
    else $error("masked flag without raw flag");
  a_irq_level:
    assert property (timer_irq == (low_timeout_masked_flag || high_timeout_masked_flag
      || clock_match_masked_flag))
    else $error("interrupt not the masked flags");
  a_raw_sticky:
    assert property (low_timeout_raw_flag && !low_timeout_clear |=> low_timeout_raw_flag)
    else $error("raw flag dropped without clear");
endmodule
bind dual_half_general_timer dual_half_general_timer_assertions
  dual_half_general_timer_assertions_i (.*);

// >>> test/dual_half_general_timer_bench.sv
// self-checking bench for the dual half general timer
// assumes the pin source and the bound checker are compiled beforehand
`timescale 1ns/1ps
module dual_half_general_timer_bench;
  // stimulus
  logic        clk_sys = 1'h0, rst_b = 1'h0, pin_run = 1'h0, capture_pin_zero;
  logic [2:0]  configuration_selector = 3'h0;
  logic [1:0]  low_half_mode_field = 2'h1, half_mode_field_high = 2'h2;
  logic [7:0]  low_half_prescale_register = 8'h00, high_half_prescale_register = 8'h00;
  logic        low_half_enable_set = 1'h0, low_half_enable_clr = 1'h0;
  logic        high_half_enable_set = 1'h0, high_half_enable_clr = 1'h0;
  logic        low_half_stall_bit = 1'h0, high_half_stall_bit = 1'h0;
  logic        low_trigger_output_enable = 1'h1, high_trigger_output_enable = 1'h0;
  logic        clock_stall_ignore_enable = 1'h0, match_we = 1'h0;
  logic        low_load_we = 1'h0, high_load_we = 1'h0;
  logic [31:0] low_load_wdata = 32'h0, match_wdata = 32'h0;
  logic [15:0] high_load_wdata = 16'h0002;
  logic        low_timeout_mask = 1'h1, high_timeout_mask = 1'h1, clock_match_mask = 1'h1;
  logic        low_timeout_clear = 1'h0, high_timeout_clear = 1'h0;
  logic        clock_match_clear_bit = 1'h0;
  // observed
  logic        low_half_enable_bit, high_half_enable_bit, timer_irq, converter_trigger;
  logic [31:0] low_half_counter_value, low_half_interval_load;
  logic [15:0] high_half_counter_value, high_half_interval_load;
  logic        low_timeout_raw_flag, high_timeout_raw_flag, clock_match_raw_flag;
  logic        low_timeout_masked_flag, high_timeout_masked_flag, clock_match_masked_flag;
  wire logic [2:0] raw_flags = {clock_match_raw_flag, high_timeout_raw_flag,
                                low_timeout_raw_flag};
  int          errors = 0, total_checks = 0, cycles = 0, trig_seen = 0;

  dual_half_general_timer dual_half_general_timer_i (.*);
  capture_clock_source capture_clock_source_i (.clk_sys, .run(pin_run), .pin(capture_pin_zero));

  always #5 clk_sys = ~clk_sys;
  // clock mode needs one full second of pin edges, about 66k cycles
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (converter_trigger === 1'h1)
      trig_seen <= trig_seen + 1;
    if (cycles == 80000)
    begin
      errors = errors + 1;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    if (errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    tick(1);
    s = 1'h0;
  endtask
  task automatic wait_flag(input int idx, input int lim);
    int n;
    n = 0;
    while (raw_flags[idx] !== 1'h1 && n < lim)
    begin
      tick(1);
      n++;
    end
    chk("raw flag", 32'h1, 32'(raw_flags[idx]));
  endtask

  task automatic t_reset;
    chk("count", 32'hffff_ffff, low_half_counter_value);
    chk("load", 32'hffff_ffff, {high_half_interval_load, low_half_interval_load[15:0]});
    chk("enables", 32'h0, {30'h0, low_half_enable_bit, high_half_enable_bit});
  endtask
  // high mode left periodic: a one-shot stop proves it is ignored
  task automatic t_oneshot32;
    int t0;
    low_load_wdata = 32'h0002_0003;
    pulse(low_load_we);
    tick(1);
    chk("load pair", 32'h0002_0003, {high_half_interval_load, low_half_interval_load[15:0]});
    chk("count pair", 32'h0002_0003, low_half_counter_value);
    low_load_wdata = 32'h0000_0005;
    pulse(low_load_we);
    t0 = trig_seen;
    pulse(low_half_enable_set);
    tick(3);
    chk("early flag", 32'h0, 32'(low_timeout_raw_flag));
    wait_flag(0, 20);
    tick(1);
    chk("one-shot stop", 32'h0, 32'(low_half_enable_bit));
    chk("masked", 32'h3, {30'h0, low_timeout_masked_flag, timer_irq});
    chk("trigger", 32'h1, trig_seen - t0);
    tick(4);
    chk("sticky", 32'h1, 32'(low_timeout_raw_flag));
    pulse(low_timeout_clear);
    chk("cleared", 32'h0, {30'h0, low_timeout_raw_flag, timer_irq});
  endtask
  task automatic t_periodic32;
    logic [31:0] v;
    low_half_mode_field = gtimer_pkg::MODE_PERIODIC;
    low_timeout_mask = 1'h0;
    low_load_wdata = 32'h0000_0004;
    pulse(low_load_we);
    pulse(low_half_enable_set);
    wait_flag(0, 20);
    pulse(low_timeout_clear);
    wait_flag(0, 20);
    chk("still on", 32'h1, 32'(low_half_enable_bit));
    chk("mask off", 32'h0, 32'(low_timeout_masked_flag));
    low_half_stall_bit = 1'h1;
    tick(2);
    v = low_half_counter_value;
    tick(5);
    chk("stalled", v, low_half_counter_value);
    low_half_stall_bit = 1'h0;
    low_load_wdata = 32'h0000_0100;
    pulse(low_load_we);
    tick(1);
    chk("live load", 32'h0000_0100, low_half_counter_value);
    tick(1);
    chk("resumed", 32'h0000_00ff, low_half_counter_value);
    pulse(low_half_enable_clr);
    tick(2);
    v = low_half_counter_value;
    tick(4);
    chk("disabled", v, low_half_counter_value);
    pulse(low_timeout_clear);
    low_timeout_mask = 1'h1;
  endtask
  task automatic t_split;
    int n;
    int t0;
    configuration_selector = gtimer_pkg::CFG_SPLIT_16;
    low_half_prescale_register = 8'h03;
    low_trigger_output_enable = 1'h0;
    high_trigger_output_enable = 1'h1;
    half_mode_field_high = gtimer_pkg::MODE_ONE_SHOT;
    // short low start so the prescaled run reaches 3 well inside the poll limit
    low_load_wdata = 32'h0000_0005;
    pulse(low_load_we);
    pulse(high_load_we);
    t0 = trig_seen;
    pulse(low_half_enable_set);
    pulse(high_half_enable_set);
    n = 0;
    while (low_half_counter_value[15:0] !== 16'h0003 && n < 40)
    begin
      tick(1);
      n++;
    end
    n = 0;
    while (low_half_counter_value[15:0] === 16'h0003 && n < 40)
    begin
      tick(1);
      n++;
    end
    chk("prescale run", 32'h4, n);
    chk("high stop", 32'h2, {30'h0, low_half_enable_bit, high_half_enable_bit});
    chk("high flags", 32'h3, {30'h0, high_timeout_raw_flag, high_timeout_masked_flag});
    chk("high trigger", 32'h1, trig_seen - t0);
    wait_flag(0, 40);
    pulse(low_half_enable_clr);
    pulse(low_timeout_clear);
    pulse(high_timeout_clear);
  endtask
  task automatic t_clock;
    configuration_selector = gtimer_pkg::CFG_32_CLOCK;
    // match equal to the start value, so the first second tick already matches
    match_wdata = 32'h0000_0001;
    pulse(match_we);
    clock_stall_ignore_enable = 1'h1;
    low_half_stall_bit = 1'h1;
    high_half_stall_bit = 1'h1;
    tick(3);
    chk("clock start", 32'h1, low_half_counter_value);
    pin_run = 1'h1;
    pulse(low_half_enable_set);
    tick(60000);
    chk("no early tick", 32'h1, low_half_counter_value);
    wait_flag(2, 8000);
    chk("match masked", 32'h3, {30'h0, clock_match_masked_flag, timer_irq});
    tick(2);
    chk("rolled", 32'h0, low_half_counter_value);
    pulse(clock_match_clear_bit);
    chk("match clear", 32'h0, {30'h0, clock_match_raw_flag, clock_match_masked_flag});
    pin_run = 1'h0;
  endtask

  initial
  begin
    tick(20);
    rst_b = 1'h1;
    tick(1);
    t_reset();
    t_oneshot32();
    t_periodic32();
    t_split();
    t_clock();
    report_and_stop();
  end
endmodule
